/* mse_engine.sv */
// modulation source engine: lfos, noise, range control, tempo lock, axi4-lite registers
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module mse_engine #(
  parameter int unsigned TICK_FAST_CYC = mse_pkg::TICK_FAST_CYC,
  parameter int unsigned TICK_SLOW_CYC = mse_pkg::TICK_SLOW_CYC,
  parameter int unsigned TICK_DEF_CYC = mse_pkg::TICK_DEF_CYC,
  parameter int unsigned NO_CLK_CYC = mse_pkg::NO_CLK_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // axi4-lite write channels
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi4-lite read channels
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // midi side, decoded by logic on clk_in
  input wire logic midi_tick_in,
  input wire logic note_trig_in,
  input wire logic program_load_in,
  input wire logic [7:0][6:0] ext_ctrl_in,
  // modulation results
  output logic [13:0] mod_value_out,
  output mse_pkg::mse_shared_s shared_out
);

  function automatic logic [31:0] rate_inc(input logic [6:0] r);
    rate_inc = ({25'h000_0000, r} + 32'h0000_0001) << mse_pkg::RATE_SHIFT;
  endfunction

  // square threshold out of 256: 64 -> 128, 0 -> 26, 127 -> 228
  function automatic logic [7:0] duty_thr(input logic [6:0] d);
    logic signed [15:0] p;
    p = ($signed({9'h000, d}) - 16'sh0040) * 16'sh0033;
    duty_thr = 8'(16'($signed({8'h00, mse_pkg::THR_MID})) + (p >>> 5));
  endfunction

  function automatic logic [6:0] note_ticks(input logic [6:0] i);
    unique case (i)
      7'h01: note_ticks = 7'h60;
      7'h02: note_ticks = 7'h30;
      7'h03: note_ticks = 7'h18;
      7'h04: note_ticks = 7'h0C;
      7'h05: note_ticks = 7'h06;
      7'h06: note_ticks = 7'h03;
      7'h07: note_ticks = 7'h10;
      7'h08: note_ticks = 7'h08;
      7'h09: note_ticks = 7'h04;
      7'h0A: note_ticks = 7'h24;
      7'h0B: note_ticks = 7'h12;
      default: note_ticks = 7'h09;
    endcase
  endfunction

  function automatic logic [6:0] lock_clamp(input logic [6:0] v);
    if (v < 7'h01) lock_clamp = 7'h01;
    else if (v > mse_pkg::LOCK_MAX) lock_clamp = mse_pkg::LOCK_MAX;
    else lock_clamp = v;
  endfunction

  // 0 linear, 1..8 convex of growing weight, 9..16 concave, others linear
  function automatic logic [6:0] curve_map(input logic [6:0] x, input logic [4:0] c);
    logic [6:0] ix;
    logic [13:0] sq;
    logic [10:0] d;
    ix = 7'h7F - x;
    sq = 14'h0000;
    d = 11'h000;
    if (c >= 5'h01 && c <= 5'h08) begin
      sq = {7'h00, x} * {7'h00, x};
      d = 11'(({4'h0, x - sq[13:7]} * {7'h00, c[3:0]}) >> 3);
      curve_map = x - d[6:0];
    end else if (c > 5'h08 && c <= mse_pkg::CURVE_LAST) begin
      sq = {7'h00, ix} * {7'h00, ix};
      d = 11'(({4'h0, ix - sq[13:7]} * {7'h00, 4'(c - 5'h08)}) >> 3);
      curve_map = x + d[6:0];
    end else begin
      curve_map = x;
    end
  endfunction

  // register state
  mse_pkg::mse_ctrl_s ctrl_r;
  mse_pkg::mse_osc_s free_r, ret_r;
  logic [4:0] curve_r;
  logic [2:0] src_r;
  logic [6:0] left_r, right_r, cutoff_r;
  logic [13:0] mod_r;
  // bus state
  logic aw_full_r, w_full_r, bvalid_r, rvalid_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r, wmask, wword;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic do_wr, aw_hs, w_hs, ar_hs;
  // tempo state
  logic [25:0] tick_cnt_r;
  logic [23:0] tick_per_r;
  logic clk_seen_r;

  function automatic logic mapped(input logic [7:0] a);
    mapped = a == mse_pkg::ADDR_CTRL || a == mse_pkg::ADDR_FREE || a == mse_pkg::ADDR_RET
      || a == mse_pkg::ADDR_SHAPE || a == mse_pkg::ADDR_DEST || a == mse_pkg::ADDR_STATUS
      || a == mse_pkg::ADDR_TEMPO;
  endfunction

  function automatic logic [31:0] reg_word(input logic [7:0] a);
    reg_word = 32'h0000_0000;
    unique case (a)
      mse_pkg::ADDR_CTRL: reg_word[7:0] = ctrl_r;
      mse_pkg::ADDR_FREE: begin
        reg_word[mse_pkg::FLD_RATE_LSB +: 7] = free_r.rate;
        reg_word[mse_pkg::FLD_DUTY_LSB +: 7] = free_r.duty;
      end
      mse_pkg::ADDR_RET: begin
        reg_word[mse_pkg::FLD_RATE_LSB +: 7] = ret_r.rate;
        reg_word[mse_pkg::FLD_DUTY_LSB +: 7] = ret_r.duty;
      end
      mse_pkg::ADDR_SHAPE: begin
        reg_word[mse_pkg::FLD_CURVE_LSB +: 5] = curve_r;
        reg_word[mse_pkg::FLD_SRC_LSB +: 3] = src_r;
      end
      mse_pkg::ADDR_DEST: begin
        reg_word[mse_pkg::FLD_LEFT_LSB +: 7] = left_r;
        reg_word[mse_pkg::FLD_RIGHT_LSB +: 7] = right_r;
      end
      mse_pkg::ADDR_STATUS: begin
        reg_word[13:0] = mod_r;
        reg_word[mse_pkg::STAT_CUT_LSB +: 7] = cutoff_r;
        reg_word[mse_pkg::STAT_SEEN_BIT] = clk_seen_r;
      end
      mse_pkg::ADDR_TEMPO: reg_word[23:0] = tick_per_r;
      default: reg_word = 32'h0000_0000;
    endcase
  endfunction

  // write path: address and data taken in either order, answer after both
  assign s_axi_awready_out = !aw_full_r && !bvalid_r;
  assign s_axi_wready_out = !w_full_r && !bvalid_r;
  assign aw_hs = s_axi_awvalid_in && s_axi_awready_out;
  assign w_hs = s_axi_wvalid_in && s_axi_wready_out;
  assign do_wr = aw_full_r && w_full_r;
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;
  assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  always_comb wword = (wdata_r & wmask) | (reg_word(awaddr_r) & ~wmask);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= mse_pkg::RESP_OKAY;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (aw_hs) begin
        aw_full_r <= 1'b1;
        awaddr_r <= s_axi_awaddr_in;
      end
      if (w_hs) begin
        w_full_r <= 1'b1;
        wdata_r <= s_axi_wdata_in;
        wstrb_r <= s_axi_wstrb_in;
      end
      if (do_wr) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= mapped(awaddr_r) ? mse_pkg::RESP_OKAY : mse_pkg::RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready_in) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // read path
  assign s_axi_arready_out = !rvalid_r;
  assign ar_hs = s_axi_arvalid_in && s_axi_arready_out;
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rdata_out = rdata_r;
  assign s_axi_rresp_out = rresp_r;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= mse_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_r <= 1'b1;
      rdata_r <= reg_word(s_axi_araddr_in);
      rresp_r <= mapped(s_axi_araddr_in) ? mse_pkg::RESP_OKAY : mse_pkg::RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready_in) begin
      rvalid_r <= 1'b0;
    end
  end

  // setting registers; one write moves every parameter sharing the setting, except pink cutoff while rate_dest is set
  logic lock_flip;
  logic [6:0] wr_rate;
  assign lock_flip = wword[2] != ctrl_r.tempo_lock;
  assign wr_rate = ctrl_r.tempo_lock ? lock_clamp(wword[mse_pkg::FLD_RATE_LSB +: 7])
                                     : wword[mse_pkg::FLD_RATE_LSB +: 7];

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_r <= '0;
      free_r <= '{duty: mse_pkg::RST_DUTY, rate: 7'h00};
      ret_r <= '{duty: mse_pkg::RST_DUTY, rate: 7'h00};
      cutoff_r <= 7'h00;
      curve_r <= 5'h00;
      src_r <= 3'h0;
      left_r <= 7'h00;
      right_r <= 7'h00;
    end else if (do_wr) begin
      unique case (awaddr_r)
        mse_pkg::ADDR_CTRL: begin
          ctrl_r <= wword[7:0];
          if (lock_flip) begin
            ret_r.rate <= wword[2] ? 7'h01 : 7'h00;
            cutoff_r <= wword[2] ? 7'h01 : 7'h00;
          end
        end
        mse_pkg::ADDR_FREE: begin
          free_r.rate <= wword[mse_pkg::FLD_RATE_LSB +: 7];
          free_r.duty <= wword[mse_pkg::FLD_DUTY_LSB +: 7];
        end
        mse_pkg::ADDR_RET: begin
          ret_r.rate <= wr_rate;
          ret_r.duty <= wword[mse_pkg::FLD_DUTY_LSB +: 7];
          if (!ctrl_r.rate_dest) cutoff_r <= wr_rate;
        end
        mse_pkg::ADDR_SHAPE: begin
          curve_r <= wword[mse_pkg::FLD_CURVE_LSB +: 5];
          src_r <= wword[mse_pkg::FLD_SRC_LSB +: 3];
        end
        mse_pkg::ADDR_DEST: begin
          left_r <= wword[mse_pkg::FLD_LEFT_LSB +: 7];
          right_r <= wword[mse_pkg::FLD_RIGHT_LSB +: 7];
        end
        default: ;
      endcase
    end
  end
  assign shared_out = '{free_osc: free_r, ret_osc: ret_r};

  // midi clock period, 24 ticks per quarter note
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tick_cnt_r <= 26'h000_0000;
      tick_per_r <= 24'(TICK_DEF_CYC);
      clk_seen_r <= 1'b0;
    end else if (midi_tick_in) begin
      tick_cnt_r <= 26'h000_0001;
      clk_seen_r <= 1'b1;
      if (clk_seen_r) begin
        if (tick_cnt_r < 26'(TICK_FAST_CYC)) tick_per_r <= 24'(TICK_FAST_CYC);
        else if (tick_cnt_r > 26'(TICK_SLOW_CYC)) tick_per_r <= 24'(TICK_SLOW_CYC);
        else tick_per_r <= tick_cnt_r[23:0];
      end
    end else begin
      if (tick_cnt_r < 26'(NO_CLK_CYC)) tick_cnt_r <= tick_cnt_r + 26'h000_0001;
      else clk_seen_r <= 1'b0;
      if (program_load_in && ctrl_r.tempo_lock && !clk_seen_r) begin
        tick_per_r <= 24'(TICK_DEF_CYC);
      end
    end
  end

  // oscillators
  logic [31:0] free_ph_r, ret_ph_r, ret_err_r, free_inc, ret_inc, sync_per, err_sum;
  logic [32:0] free_sum;
  logic free_wrap;
  assign ret_inc = rate_inc(ret_r.rate);
  assign free_inc = rate_inc(free_r.rate) << 2;
  assign free_sum = {1'b0, free_ph_r} + {1'b0, free_inc};
  assign free_wrap = free_sum[32];
  assign sync_per = {8'h00, tick_per_r} * {25'h000_0000, note_ticks(lock_clamp(ret_r.rate))};
  assign err_sum = ret_err_r + mse_pkg::SYNC_STEP;

  always_ff @(posedge clk_in) begin
    if (rst_in) free_ph_r <= 32'h0000_0000;
    else free_ph_r <= free_sum[31:0];
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || note_trig_in) begin
      ret_ph_r <= 32'h0000_0000;
      ret_err_r <= 32'h0000_0000;
    end else if (ctrl_r.tempo_lock) begin
      if (err_sum >= sync_per) begin
        ret_err_r <= err_sum - sync_per;
        ret_ph_r <= ret_ph_r + mse_pkg::SYNC_STEP;
      end else begin
        ret_err_r <= err_sum;
      end
    end else begin
      ret_ph_r <= ret_ph_r + ret_inc;
      ret_err_r <= 32'h0000_0000;
    end
  end

  // noise
  logic [15:0] lfsr_r;
  localparam int PINK_W = mse_pkg::PINK_FRAC + 7;
  logic [6:0] white_r, pink;
  logic [PINK_W-1:0] pink_acc_r;
  logic signed [PINK_W:0] pink_diff;
  logic [4:0] pink_sh;
  assign pink_sh = mse_pkg::PINK_SH_BASE - {1'b0, cutoff_r[6:3]};
  assign pink_diff = $signed({1'b0, white_r, {mse_pkg::PINK_FRAC{1'b0}}})
    - $signed({1'b0, pink_acc_r});
  assign pink = pink_acc_r[PINK_W-1 -: 7];

  always_ff @(posedge clk_in) begin
    if (rst_in) lfsr_r <= mse_pkg::LFSR_SEED;
    else lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) white_r <= 7'h00;
    else if (free_wrap) white_r <= lfsr_r[6:0];
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) pink_acc_r <= '0;
    else pink_acc_r <= pink_acc_r + PINK_W'(pink_diff >>> pink_sh);
  end

  // source select, curve, range depth, destination
  logic [7:0] free_thr, ret_thr, depth8, s8;
  logic [6:0] src_val, shaped, rng_v, depth, scaled;
  logic [14:0] sc_prod;
  logic signed [16:0] dev;
  logic [14:0] dest_val;
  assign free_thr = duty_thr(free_r.duty);
  assign ret_thr = duty_thr(ret_r.duty);

  always_comb begin
    unique case (mse_pkg::mse_src_e'(src_r))
      mse_pkg::SRC_FREE_SAW: src_val = free_ph_r[31:25];
      mse_pkg::SRC_FREE_SQR: src_val = free_ph_r[31:24] < free_thr ? 7'h7F : 7'h00;
      mse_pkg::SRC_FREE_TRI: src_val = free_ph_r[31] ? ~free_ph_r[30:24] : free_ph_r[30:24];
      mse_pkg::SRC_RET_SAW: src_val = ret_ph_r[31:25];
      mse_pkg::SRC_RET_SQR: src_val = ret_ph_r[31:24] < ret_thr ? 7'h7F : 7'h00;
      mse_pkg::SRC_RET_TRI: src_val = ret_ph_r[31] ? ~ret_ph_r[30:24] : ret_ph_r[30:24];
      mse_pkg::SRC_WHITE: src_val = white_r;
      mse_pkg::SRC_PINK: src_val = pink;
    endcase
  end

  assign shaped = curve_map(src_val, curve_r);
  assign rng_v = ext_ctrl_in[ctrl_r.range_sel];
  assign depth = !ctrl_r.range_en ? 7'h7F : ctrl_r.range_neg ? 7'h7F - rng_v : rng_v;
  assign depth8 = {1'b0, depth} + {7'h00, depth[6]};
  assign sc_prod = {8'h00, shaped} * {7'h00, depth8};
  assign scaled = sc_prod[13:7];
  assign s8 = {1'b0, scaled} + {7'h00, scaled[6]};
  assign dev = ($signed({10'h000, right_r}) - $signed({10'h000, left_r}))
    * $signed({9'h000, s8});
  assign dest_val = 15'($signed({1'b0, left_r, 7'h00}) + dev);

  always_ff @(posedge clk_in) begin
    if (rst_in) mod_r <= 14'h0000;
    else if (ctrl_r.stepped) mod_r <= {dest_val[13:7], 7'h00};
    else mod_r <= dest_val[13:0];
  end
  assign mod_value_out = mod_r;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_pos_suppress: assert property (ctrl_r.range_en && !ctrl_r.range_neg && rng_v == 7'h00
    |=> mod_r == {$past(left_r), 7'h00}) else $error("positive range 0 did not suppress");
  a_neg_full: assert property (ctrl_r.range_en && ctrl_r.range_neg && rng_v == 7'h00
    |-> scaled == shaped) else $error("negative range 0 not full depth");
  a_rate_ratio: assert property (free_r.rate == ret_r.rate |-> free_inc == {ret_inc[29:0], 2'b00})
    else $error("free lfo not four times faster");
  a_note_reset: assert property (note_trig_in |=> ret_ph_r == 32'h0000_0000
    && free_ph_r == $past(free_ph_r) + $past(free_inc)) else $error("note reset wrong");
  a_duty_mid: assert property (free_r.duty == 7'h40 |-> free_thr == 8'h80)
    else $error("duty 64 not symmetric");
  a_white_hold: assert property (!free_wrap |=> $stable(white_r))
    else $error("white noise changed between samples");
  a_cut_block: assert property (do_wr && awaddr_r == mse_pkg::ADDR_RET && ctrl_r.rate_dest
    |=> $stable(cutoff_r)) else $error("pink cutoff moved while blocked");
  a_step_whole: assert property (ctrl_r.stepped && $past(ctrl_r.stepped) |-> mod_r[6:0] == 7'h00)
    else $error("stepped output has fraction");
  a_lock_reset: assert property (do_wr && awaddr_r == mse_pkg::ADDR_CTRL && lock_flip
    |=> ret_r.rate <= 7'h01 && cutoff_r <= 7'h01) else $error("lock toggle did not reset rate");
  a_lock_range: assert property (ctrl_r.tempo_lock && $past(ctrl_r.tempo_lock)
    |-> ret_r.rate >= 7'h01 && ret_r.rate <= mse_pkg::LOCK_MAX) else $error("locked rate out of 1..12");
  a_tempo_clamp: assert property (##1 tick_per_r >= 24'(TICK_FAST_CYC)
    && tick_per_r <= 24'(TICK_SLOW_CYC)) else $error("tempo outside clamp");

  c_sync_note: cover property (ctrl_r.tempo_lock && note_trig_in);
  c_white_new: cover property (free_wrap ##1 $changed(white_r));
  c_lock_flip: cover property (do_wr && awaddr_r == mse_pkg::ADDR_CTRL && lock_flip);
  c_bad_addr: cover property (bvalid_r && bresp_r == mse_pkg::RESP_SLVERR);
endmodule

/* mse_engine_bench.sv */
// self-checking bench of the modulation source engine
`timescale 1ns/1ps
module mse_engine_bench;
  localparam int unsigned FAST = 22000;
  localparam int unsigned SLOW = 24000;
  localparam int unsigned DEF = 23000;
  localparam logic [1:0] OK = mse_pkg::RESP_OKAY;
  typedef struct {string nm; logic [31:0] d; logic [31:0] m; logic [1:0] r;} mse_exp_s;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
  logic awr, wrd, bv, arr, rv, tick, note, load;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0][6:0] ext;
  logic [13:0] mod;
  mse_pkg::mse_shared_s shr;
  int mismatches = 0;
  int n_compared = 0;
  mse_exp_s rq[$];
  logic [1:0] bq[$];
  mse_exp_s cur;
  always #2.5 clk_in = ~clk_in;
  mse_engine #(.TICK_FAST_CYC(FAST), .TICK_SLOW_CYC(SLOW), .TICK_DEF_CYC(DEF),
    .NO_CLK_CYC(25000)) dut (.clk_in(clk_in), .rst_in(rst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrd), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(brd), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rrd), .midi_tick_in(tick),
    .note_trig_in(note), .program_load_in(load), .ext_ctrl_in(ext),
    .mod_value_out(mod), .shared_out(shr));
  mse_midi_src src (.clk_in(clk_in), .midi_tick_out(tick), .note_trig_out(note),
    .program_load_out(load), .ext_ctrl_out(ext));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test;
    if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // results are compared in the order they were requested
  always @(posedge clk_in) begin
    if (rv && rrd && rq.size() > 0) begin
      cur = rq.pop_front();
      chk(cur.nm, cur.d & cur.m, rdata & cur.m);
      chk({cur.nm, " resp"}, 32'(cur.r), 32'(rresp));
    end
    if (bv && brd && bq.size() > 0) chk("write resp", 32'(bq.pop_front()), 32'(bresp));
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit sa, sw, tb;
    bq.push_back(r);
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    for (int n = 0; n < 50 && !tb; n++) begin
      @(negedge clk_in);
      sa = awv && awr;
      sw = wv && wrd;
      tb = bv && brd;
      @(posedge clk_in);
      if (sa) awv <= 1'b0;
      if (sw) wv <= 1'b0;
      if (tb) brd <= 1'b0;
    end
    if (!tb) chk("write answer", 32'h1, 32'h0);
    if (!tb) finish_test();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] r);
    bit sa, tr;
    rq.push_back('{$sformatf("reg %h", a), d, m, r});
    @(posedge clk_in);
    araddr <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    for (int n = 0; n < 50 && !tr; n++) begin
      @(negedge clk_in);
      sa = arv && arr;
      tr = rv && rrd;
      @(posedge clk_in);
      if (sa) arv <= 1'b0;
      if (tr) rrd <= 1'b0;
    end
    if (!tr) chk("read answer", 32'h1, 32'h0);
    if (!tr) finish_test();
  endtask
  initial begin
    logic [6:0] v, u;
    bit full;
    void'($urandom(32'h05b7));
    for (int i = 0; i < 8; i++) src.set_ctrl(i, 7'($urandom));
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(mse_pkg::ADDR_CTRL, 32'h0000_0000, 32'hffff_ffff, OK);
    rd(mse_pkg::ADDR_FREE, 32'h0000_4000, 32'hffff_ffff, OK);
    rd(mse_pkg::ADDR_SHAPE, 32'h0000_0000, 32'hffff_ffff, OK);
    rd(mse_pkg::ADDR_TEMPO, 32'(DEF), 32'hffff_ffff, OK);
    rd(8'h1C, 32'h0000_0000, 32'hffff_ffff, mse_pkg::RESP_SLVERR);
    wr(8'h1C, 32'h0000_1234, mse_pkg::RESP_SLVERR);
    chk("shared", {7'h40, 7'h00, 7'h40, 7'h00}, 32'(shr));
    for (int i = 0; i < 3; i++) begin
      v = 7'($urandom);
      u = 7'($urandom);
      wr(mse_pkg::ADDR_FREE, {17'h0, u, 1'b0, v}, OK);
      chk("free shared", {u, v}, 32'(shr.free_osc));
      wr(mse_pkg::ADDR_RET, {17'h0, v, 1'b0, u}, OK);
      chk("ret shared", {v, u}, 32'(shr.ret_osc));
      rd(mse_pkg::ADDR_STATUS, {9'h0, u, 16'h0}, 32'h007f_0000, OK);
    end
    wr(mse_pkg::ADDR_CTRL, 32'h0000_0008, OK);
    wr(mse_pkg::ADDR_RET, {25'h0, ~u}, OK);
    rd(mse_pkg::ADDR_STATUS, {9'h0, u, 16'h0}, 32'h007f_0000, OK);
    wr(mse_pkg::ADDR_CTRL, 32'h0000_0004, OK);
    rd(mse_pkg::ADDR_STATUS, 32'h0001_0000, 32'h007f_0000, OK);
    wr(mse_pkg::ADDR_RET, 32'h0000_0064, OK);
    rd(mse_pkg::ADDR_RET, 32'h0000_000c, 32'h0000_007f, OK);
    rd(mse_pkg::ADDR_STATUS, 32'h000c_0000, 32'h007f_0000, OK);
    wr(mse_pkg::ADDR_CTRL, 32'h0000_0000, OK);
    rd(mse_pkg::ADDR_RET, 32'h0000_0000, 32'h0000_007f, OK);
    wr(mse_pkg::ADDR_DEST, 32'h0000_7f0a, OK);
    wstrb <= 4'h2;
    wr(mse_pkg::ADDR_DEST, 32'h0000_1433, OK);
    wstrb <= 4'hf;
    rd(mse_pkg::ADDR_DEST, 32'h0000_140a, 32'hffff_ffff, OK);
    wr(mse_pkg::ADDR_SHAPE, 32'h0000_0400, OK);
    src.pulse(1'b0);
    for (int i = 0; i < 8; i++) begin
      for (int j = 0; j < 4; j++) begin
        full = j[0] ^ j[1];
        wr(mse_pkg::ADDR_CTRL, 32'((i << 5) | 16 | j[1]), OK);
        src.set_ctrl(i, j[0] ? 7'h7f : 7'h00);
        repeat (3) @(posedge clk_in);
        rd(mse_pkg::ADDR_STATUS, full ? 32'h0a00 : 32'h0500, 32'h3fff, OK);
        chk("mod", full ? 32'h0a00 : 32'h0500, 32'(mod));
      end
    end
    wr(mse_pkg::ADDR_CTRL, 32'h0000_0012, OK);
    src.set_ctrl(0, 7'h40);
    repeat (3) @(posedge clk_in);
    rd(mse_pkg::ADDR_STATUS, 32'h0780, 32'h3fff, OK);
    wr(mse_pkg::ADDR_CTRL, 32'h0000_0010, OK);
    rd(mse_pkg::ADDR_STATUS, 32'h0780, 32'h3f80, OK);
    wr(mse_pkg::ADDR_CTRL, 32'h0000_0004, OK);
    src.tick(1000);
    src.tick(5);
    rd(mse_pkg::ADDR_TEMPO, 32'(FAST), 32'hffff_ffff, OK);
    src.tick(23500);
    src.tick(5);
    rd(mse_pkg::ADDR_TEMPO, 32'd23500, 32'hffff_ffff, OK);
    src.tick(24500);
    src.tick(5);
    src.pulse(1'b1);
    rd(mse_pkg::ADDR_TEMPO, 32'(SLOW), 32'hffff_ffff, OK);
    rd(mse_pkg::ADDR_STATUS, 32'h0100_0000, 32'h0100_0000, OK);
    repeat (25010) @(posedge clk_in);
    src.pulse(1'b1);
    rd(mse_pkg::ADDR_TEMPO, 32'(DEF), 32'hffff_ffff, OK);
    rd(mse_pkg::ADDR_STATUS, 32'h0000_0000, 32'h0100_0000, OK);
    repeat (5) @(posedge clk_in);
    finish_test();
  end
endmodule

/* mse_midi_src.sv */
// midi source model: timing clocks, note triggers, program loads, controllers
`timescale 1ns/1ps
module mse_midi_src (
  // clock
  input wire logic clk_in,
  // events towards the engine
  output logic midi_tick_out,
  output logic note_trig_out,
  output logic program_load_out,
  output logic [7:0][6:0] ext_ctrl_out
);
  initial begin
    midi_tick_out = 1'b0;
    note_trig_out = 1'b0;
    program_load_out = 1'b0;
    ext_ctrl_out = '0;
  end
  // one timing clock; the next one may follow gap cycles later
  task automatic tick(input int gap);
    @(posedge clk_in);
    midi_tick_out <= 1'b1;
    @(posedge clk_in);
    midi_tick_out <= 1'b0;
    repeat (gap - 2) @(posedge clk_in);
  endtask
  // one-cycle note or program pulse
  task automatic pulse(input bit ld);
    @(posedge clk_in);
    if (ld) program_load_out <= 1'b1;
    else note_trig_out <= 1'b1;
    @(posedge clk_in);
    program_load_out <= 1'b0;
    note_trig_out <= 1'b0;
  endtask
  task automatic set_ctrl(input int k, input logic [6:0] v);
    ext_ctrl_out[k] <= v;
  endtask
endmodule

/* mse_pkg.sv */
// constants, register map and types of the modulation source engine
//
// Behaviour
// - positive polarity: range value 127 gives full depth, 0 suppresses modulation
// - negative polarity: range value 0 gives full depth, 127 suppresses modulation
// - any external source may act as the range controller
// - free-running lfo runs four times the retriggered lfo rate per setting
// - notes never reset the free-running lfo; each note resets the retriggered lfo
// - both lfos offer saw, square and triangle as separate sources
// - duty setting 64 gives 50%, 0 about 10%, 127 about 90%
// - a shared rate or duty write updates both mapped parameters at once
// - white noise resampled at the free-running lfo rate, held between samples
// - pink noise is lowpassed white noise, cutoff set by retriggered rate
// - while that rate is a modulation destination, pink cutoff stays untouched; toggling tempo lock still resets it
// - stepped mode moves in whole semitones; continuous mode moves smoothly
// - tempo lock takes retriggered lfo rate from midi clock; notes still reset
// - under lock the rate setting picks a note length, triplets and dotted too
// - measured tempo is clamped to 30 to 480 bpm
// - no midi clock at tempo-locked program load gives 120 bpm
// - toggling tempo lock resets retriggered rate and pink cutoff to minimum
// - under tempo lock rate and pink cutoff are limited to steps 1 to 12
// - seventeen transfer curves shape the modulation; linear is the default
// - left value is the base, right value the level reached at full amplitude
package mse_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FREE = 8'h04;
  localparam logic [7:0] ADDR_RET = 8'h08;
  localparam logic [7:0] ADDR_SHAPE = 8'h0C;
  localparam logic [7:0] ADDR_DEST = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_TEMPO = 8'h18;
  // field positions
  localparam int FLD_RATE_LSB = 0;
  localparam int FLD_DUTY_LSB = 8;
  localparam int FLD_CURVE_LSB = 0;
  localparam int FLD_SRC_LSB = 8;
  localparam int FLD_LEFT_LSB = 0;
  localparam int FLD_RIGHT_LSB = 8;
  localparam int STAT_CUT_LSB = 16;
  localparam int STAT_SEEN_BIT = 24;
  // reset values
  localparam logic [6:0] RST_DUTY = 7'h40;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // oscillator and filter scaling
  localparam int RATE_SHIFT = 8;
  localparam logic [31:0] SYNC_STEP = 32'h0001_0000;
  localparam logic [7:0] THR_MID = 8'h80;
  localparam logic [6:0] LOCK_MAX = 7'h0C;
  localparam int PINK_FRAC = 20;
  localparam logic [4:0] PINK_SH_BASE = 5'h1C;
  localparam logic [4:0] CURVE_LAST = 5'h10;
  // tempo figures and derived tick periods in clock cycles
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned PPQN = 24;
  localparam int unsigned BPM_MIN = 30;
  localparam int unsigned BPM_MAX = 480;
  localparam int unsigned BPM_DEF = 120;
  localparam int unsigned TICK_SLOW_CYC = CLK_HZ / PPQN * 60 / BPM_MIN;
  localparam int unsigned TICK_FAST_CYC = (CLK_HZ / PPQN * 60 + BPM_MAX - 1) / BPM_MAX;
  localparam int unsigned TICK_DEF_CYC = CLK_HZ / PPQN * 60 / BPM_DEF;
  localparam int unsigned NO_CLK_CYC = 2 * TICK_SLOW_CYC;

  typedef struct packed {
    logic [2:0] range_sel;
    logic range_en;
    logic rate_dest;
    logic tempo_lock;
    logic stepped;
    logic range_neg;
  } mse_ctrl_s;

  typedef struct packed {
    logic [6:0] duty;
    logic [6:0] rate;
  } mse_osc_s;

  typedef struct packed {
    mse_osc_s free_osc;
    mse_osc_s ret_osc;
  } mse_shared_s;

  typedef enum logic [2:0] {
    SRC_FREE_SAW = 3'h0,
    SRC_FREE_SQR = 3'h1,
    SRC_FREE_TRI = 3'h2,
    SRC_RET_SAW = 3'h3,
    SRC_RET_SQR = 3'h4,
    SRC_RET_TRI = 3'h5,
    SRC_WHITE = 3'h6,
    SRC_PINK = 3'h7
  } mse_src_e;
endpackage
